/* File: adc_control_result_logic.sv */
// adc_control_result_logic: control, sequencing and result registers of
// an eight-channel 10-bit converter, reached over APB
// assumes the analog core converts channel_select on each conv_tick and
// returns one sample with a one-cycle valid strobe after conv_start
`timescale 1ns/1ps
`default_nettype none

// How it works
// - interrupt-enable set raises interrupt per conversion
// - irq mode: done flag writable, zero while signalling
// - data read or control write drops interrupt
// - polled mode: done flag read-only, set per conversion
// - polled mode: control write, data read clear done; reset clears done
// - control write aborts and restarts conversion
// - reset clears interrupt enable and continuous
// - continuous converts back to back; else once
// - codes 0..7 select external inputs 0..7
// - codes 1D/1E select high/low reference
// - other codes unused; 1B factory test
// - all-ones channel powers converter down
// - first conversion after power-up only settles
// - converter and interrupt keep working in wait
// - left format: eight msbs high, two lsbs low
// - right format: two msbs high, eight low
// - results load per conversion unless interlocked
// - high read freezes low until low read
// - results arriving while frozen are dropped
// - two-bit format field, reset selects right
// - truncation: eight msbs low, no interlock
// - signed format inverts result msb
// - conversion lasts 16 to 17 converter clocks
module adc_control_result_logic (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [adc_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire adc_pkg::sample_t             sample,
  output logic                              conv_tick,
  output logic                              conv_start,
  output logic                              core_power,
  output logic      [4:0]                   channel_select,
  output logic                              conv_irq
);
  import adc_pkg::*;

  typedef struct packed {
    conv_state_t st;
    logic [4:0]  cnt;
    logic        start;
    logic        irq_en;
    logic        cont;
    logic [4:0]  chan;
    logic        done;
    logic        irq;
    logic        lock;
    logic        settle;
    logic        power;
    logic [2:0]  div;
    logic        clk_src;
    fmt_t        fmt;
    logic [7:0]  rh;
    logic [7:0]  rl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ctrl_state_t;

  ctrl_state_t  s_q;
  ctrl_state_t  s_d;
  result_pair_t fmt_res;
  logic         tick;
  logic         setup;
  logic         access;
  logic         wr_sc;
  logic         wr_clk;
  logic         rd_rh;
  logic         rd_rl;
  logic         rd_res;
  logic         accept;
  logic [4:0]   wr_chan;

  conv_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div_sel (s_q.div),
    .tick    (tick)
  );

  result_format u_fmt (
    .fmt         (s_q.fmt),
    .sample_data (sample.data),
    .result      (fmt_res)
  );

  always_comb begin
    setup   = psel && !penable;
    access  = psel && penable && s_q.pready;
    wr_sc   = access && pwrite && (paddr == OFF_STATUS_CTRL);
    wr_clk  = access && pwrite && (paddr == OFF_CLOCK_CFG);
    rd_rh   = access && !pwrite && (paddr == OFF_RESULT_HIGH);
    rd_rl   = access && !pwrite && (paddr == OFF_RESULT_LOW);
    rd_res  = rd_rh || rd_rl;
    wr_chan = pwdata[SC_CHAN_LSB +: 5];
    accept  = (s_q.st == ST_WAIT) && sample.valid;

    s_d = s_q;
    s_d.start   = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    s_d.pslverr = 1'b0;
    // zero wait states: ready is raised for the access phase
    s_d.pready  = setup;

    // register read data is captured in the setup cycle
    if (setup && !pwrite) begin
      case (paddr)
        OFF_STATUS_CTRL: s_d.prdata = {24'h00_0000, s_q.done, s_q.irq_en, s_q.cont, s_q.chan};
        OFF_RESULT_HIGH: s_d.prdata = {24'h00_0000, s_q.rh};
        OFF_RESULT_LOW:  s_d.prdata = {24'h00_0000, s_q.rl};
        OFF_CLOCK_CFG:   s_d.prdata = {24'h00_0000, s_q.div, s_q.clk_src, s_q.fmt, 2'h0};
        default:         s_d.pslverr = 1'b1;
      endcase
    end else if (setup) begin
      unique case (paddr)
        OFF_STATUS_CTRL, OFF_RESULT_HIGH, OFF_RESULT_LOW, OFF_CLOCK_CFG: s_d.pslverr = 1'b0;
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // sync to converter clock, then 16 cycles
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.st = ST_IDLE;
      end
      ST_SYNC: begin
        if (tick) begin
          s_d.st    = ST_CONV;
          s_d.cnt   = 5'h00;
          s_d.start = 1'b1;
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (s_q.cnt == CONV_CYCLES - 5'h01) begin
            s_d.st = ST_WAIT;
          end else begin
            s_d.cnt = s_q.cnt + 5'h01;
          end
        end
      end
      ST_WAIT: begin
        if (accept) begin
          s_d.st = (s_q.cont || s_q.settle) ? ST_SYNC : ST_IDLE;
        end
      end
    endcase

    // a powered-down converter must settle first
    if (s_q.chan == CHAN_POWER_OFF) begin
      s_d.settle = 1'b1;
    end

    if (wr_clk) begin
      s_d.fmt     = fmt_t'(pwdata[CFG_FMT_LSB +: 2]);
      s_d.div     = pwdata[CFG_DIV_LSB +: 3];
      // single clock design: source bit is stored only
      s_d.clk_src = pwdata[CFG_SRC_BIT];
    end

    if (rd_res) begin
      s_d.irq = 1'b0;
      // polled flag cleared by data read
      if (!s_q.irq_en) begin
        s_d.done = 1'b0;
      end
    end

    // high read freezes the low result
    if (rd_rh && (s_q.fmt != FMT_TRUNC)) begin
      s_d.lock = 1'b1;
    end
    if (rd_rl) begin
      s_d.lock = 1'b0;
    end

    if (wr_sc) begin
      s_d.irq_en = pwdata[SC_IRQEN_BIT];
      s_d.cont   = pwdata[SC_CONT_BIT];
      s_d.chan   = wr_chan;
      s_d.irq    = 1'b0;
      // irq mode keeps the written bit
      s_d.done   = pwdata[SC_IRQEN_BIT] ? pwdata[SC_DONE_BIT] : 1'b0;
      // abort and restart with new settings
      // power-off code leaves the sequencer idle
      s_d.st     = (wr_chan == CHAN_POWER_OFF) ? ST_IDLE : ST_SYNC;
      s_d.cnt    = 5'h00;
    end

    // flag setting comes last so a same-cycle clear loses
    if (accept) begin
      if (s_q.settle) begin
        s_d.settle = 1'b0;
      end else begin
        if (!s_q.lock || (s_q.fmt == FMT_TRUNC)) begin
          s_d.rh = fmt_res.high;
          s_d.rl = fmt_res.low;
        end
        if (s_q.irq_en) begin
          s_d.irq  = 1'b1;
          s_d.done = 1'b0;
        end else begin
          s_d.done = 1'b1;
        end
      end
    end

    // analog core unpowered on the off code
    s_d.power = (s_d.chan != CHAN_POWER_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: ST_IDLE, chan: CHAN_RESET, div: DIV_RESET, clk_src: CLK_SRC_RESET,
               fmt: FMT_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign conv_tick  = tick;
  assign conv_start = s_q.start;
  assign core_power = s_q.power;
  // channel code passed to the input mux
  // reference codes reach the core unchanged
  // unused codes give whatever the core makes
  assign channel_select = s_q.chan;
  // no wait gating, interrupt can wake
  assign conv_irq   = s_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_quiet;
    !wr_sc && !wr_clk;
  endsequence

  sequence s_conv_run;
    s_quiet [*8] ##1 s_quiet [*7];
  endsequence

  sequence s_ctrl_write;
    wr_sc && (wr_chan != CHAN_POWER_OFF);
  endsequence

  property p_irq_on_done;
    accept && s_q.irq_en && !s_q.settle |=> conv_irq && !s_q.done;
  endproperty
  a_irq_on_done: assert property (p_irq_on_done)
    else $error("interrupt not raised after conversion");

  property p_flag_low_in_irq;
    s_q.irq_en && conv_irq |-> !s_q.done;
  endproperty
  a_flag_low_in_irq: assert property (p_flag_low_in_irq)
    else $error("done flag high while interrupt pending");

  property p_irq_clear;
    (wr_sc || rd_res) && !accept |=> !conv_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt survived clearing access");

  property p_done_polled;
    accept && !s_q.irq_en && !s_q.settle |=> s_q.done;
  endproperty
  a_done_polled: assert property (p_done_polled)
    else $error("done flag not set after conversion");

  property p_done_clear;
    rd_res && !accept && !s_q.irq_en |=> !s_q.done;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag not cleared by data read");

  property p_abort;
    s_ctrl_write |=> (s_q.st == ST_SYNC) && core_power;
  endproperty
  a_abort: assert property (p_abort)
    else $error("control write did not restart conversion");

  property p_single_stop;
    accept && !s_q.cont && !s_q.settle && !wr_sc |=> s_q.st == ST_IDLE;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single mode converted again");

  property p_power_off;
    (s_q.chan == CHAN_POWER_OFF) && !wr_sc |=> (s_q.st == ST_IDLE) && !core_power;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("converter active on power-off code");

  property p_settle_drop;
    accept && s_q.settle && !wr_sc |=> $stable(s_q.rh) && $stable(s_q.rl) && !s_q.done;
  endproperty
  a_settle_drop: assert property (p_settle_drop)
    else $error("settling result was stored");

  property p_locked_keep;
    accept && s_q.lock && (s_q.fmt != FMT_TRUNC) |=> $stable(s_q.rl) && $stable(s_q.rh);
  endproperty
  a_locked_keep: assert property (p_locked_keep)
    else $error("frozen result was overwritten");

  property p_conv_len;
    (s_q.start && (s_q.div == DIV_RESET) && !wr_sc && !wr_clk) ##1 s_conv_run
      |=> s_q.st == ST_WAIT;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length not 16 converter clocks");

endmodule : adc_control_result_logic
`default_nettype wire

/* File: adc_pkg.sv */
// adc_pkg: constants, enumerations and carriers of the converter control block
// assumes a 32-bit APB slave port with byte addresses, one word per register
package adc_pkg;

  localparam int unsigned PADDR_W = 8;

  // byte offsets of the registers
  localparam logic [7:0] OFF_STATUS_CTRL = 8'h00;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h08;
  localparam logic [7:0] OFF_CLOCK_CFG   = 8'h0C;

  // status/control fields
  localparam int unsigned SC_DONE_BIT  = 7;
  localparam int unsigned SC_IRQEN_BIT = 6;
  localparam int unsigned SC_CONT_BIT  = 5;
  localparam int unsigned SC_CHAN_LSB  = 0;

  // clock configuration fields
  localparam int unsigned CFG_DIV_LSB = 5;
  localparam int unsigned CFG_SRC_BIT = 4;
  localparam int unsigned CFG_FMT_LSB = 2;

  // channel codes and values after reset
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
  localparam logic [4:0] CHAN_RESET     = 5'h1F;
  localparam logic [2:0] DIV_RESET      = 3'h0;
  localparam logic       CLK_SRC_RESET  = 1'b0;
  localparam logic [3:0] DIV_CNT_RESET  = 4'h0;

  // converter clock cycles of one conversion after the start cycle
  localparam logic [4:0] CONV_CYCLES = 5'h10;

  typedef enum logic [1:0] {
    FMT_TRUNC  = 2'h0,
    FMT_RIGHT  = 2'h1,
    FMT_LEFT   = 2'h2,
    FMT_SIGNED = 2'h3
  } fmt_t;

  localparam fmt_t FMT_RESET = FMT_RIGHT;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_CONV = 4'h4,
    ST_WAIT = 4'h8
  } conv_state_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } sample_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

endpackage : adc_pkg

/* File: conv_clk_div.sv */
// conv_clk_div: converter clock enable, one pulse per divided period
// assumes div_sel is stable between writes; a change restarts no count
`timescale 1ns/1ps
`default_nettype none
module conv_clk_div (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  import adc_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [3:0] last;

  always_comb begin
    // ratios 1, 2, 4, 8, and 16 for any code with the top bit set
    last = div_sel[2] ? 4'hF : (4'h1 << div_sel[1:0]) - 4'h1;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= last) begin
      s_d.cnt = DIV_CNT_RESET;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cnt: DIV_CNT_RESET, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : conv_clk_div
`default_nettype wire

/* File: result_format.sv */
// result_format: places a 10-bit sample into the high/low result pair
// assumes the caller registers the pair; purely combinational
`timescale 1ns/1ps
`default_nettype none
module result_format (
  input  wire adc_pkg::fmt_t     fmt,
  input  wire logic [9:0]        sample_data,
  output var adc_pkg::result_pair_t result
);
  import adc_pkg::*;

  always_comb begin
    unique case (fmt)
      FMT_TRUNC: begin
        result.high = 8'h00;
        result.low  = sample_data[9:2];
      end
      FMT_RIGHT: begin
        result.high = {6'h00, sample_data[9:8]};
        result.low  = sample_data[7:0];
      end
      FMT_LEFT: begin
        result.high = sample_data[9:2];
        result.low  = {sample_data[1:0], 6'h00};
      end
      FMT_SIGNED: begin
        result.high = {~sample_data[9], sample_data[8:2]};
        result.low  = {sample_data[1:0], 6'h00};
      end
    endcase
  end

endmodule : result_format
`default_nettype wire

/* File: adc_core_model.sv */
// adc_core_model: behavioural analog core beside the sequencer
// assumes one sample per conv_start, answered 16 ticks later or slower
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            conv_tick,
  input  wire logic            conv_start,
  input  wire logic            core_power,
  input  wire logic [4:0]      channel_select,
  input  wire logic [9:0]      level,
  input  wire logic [3:0]      extra,
  output var adc_pkg::sample_t sample
);
  import adc_pkg::*;
  int cnt;

  function automatic logic [9:0] pick(input logic [4:0] c, input logic [9:0] l);
    if (c == 5'h1D) begin
      return 10'h3FF;
    end
    if (c == 5'h1E) begin
      return 10'h000;
    end
    return l;
  endfunction : pick

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= 0;
      sample <= '0;
    end else begin
      sample.valid <= 1'b0;
      // idle data keeps toggling, never a stale value
      sample.data  <= ~sample.data;
      if (!core_power) begin
        cnt <= 0;
      end else if (conv_start) begin
        cnt <= 1;
      end else if (cnt >= 17 + int'(extra)) begin
        cnt          <= 0;
        sample.valid <= 1'b1;
        sample.data  <= pick(channel_select, level);
      end else if (cnt > 0 && conv_tick) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : adc_core_model
`default_nettype wire

/* File: adc_control_result_logic_bench.sv */
// adc_control_result_logic_bench: self-checking bench over APB
// assumes the core model answers each start; clock 10 MHz
`timescale 1ns/1ps
`default_nettype none
module adc_control_result_logic_bench;
  import adc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  sample_t     sample;
  logic        conv_tick;
  logic        conv_start;
  logic        core_power;
  logic [4:0]  channel_select;
  logic        conv_irq;
  logic [9:0]  level;
  logic [3:0]  extra;
  logic [31:0] rd;
  logic        er;
  int          failures;
  int          compares;
  int          cycles;
  int          v;
  int          ch;
  int          exp_h;
  int          exp_l;
  int          cfg;
  int          ticks;
  int          starts;
  int          t0;
  int          s0;

  adc_control_result_logic u_adc_control_result_logic (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample(sample),
    .conv_tick(conv_tick), .conv_start(conv_start), .core_power(core_power),
    .channel_select(channel_select), .conv_irq(conv_irq));

  adc_core_model u_adc_core_model (
    .pclk(pclk), .presetn(presetn), .conv_tick(conv_tick),
    .conv_start(conv_start), .core_power(core_power),
    .channel_select(channel_select), .level(level), .extra(extra),
    .sample(sample));

  always #50 pclk = ~pclk;

  // hang guard, far above the longest sequence
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  // converter clock and start pulses seen by the core
  always @(posedge pclk) begin
    if (conv_tick === 1'b1) begin
      ticks++;
    end
    if (conv_start === 1'b1) begin
      starts++;
    end
  end

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_done();
    int n;
    n = 0;
    rd = 0;
    while (rd[7] !== 1'b1 && n < 300) begin
      apb(0, OFF_STATUS_CTRL, 0);
      n++;
    end
    check("done", rd[7], 1);
  endtask : wait_done

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (conv_irq !== 1'b1 && n < 400);
    check("irq", conv_irq, 1);
  endtask : wait_irq

  task automatic read_pair(input int f, input int x);
    case (f)
      0: begin
        exp_h = 0;
        exp_l = x >> 2;
      end
      1: begin
        exp_h = x >> 8;
        exp_l = x & 255;
      end
      default: begin
        exp_h = (f == 3) ? ((x >> 2) ^ 128) : (x >> 2);
        exp_l = (x & 3) << 6;
      end
    endcase
    apb(0, OFF_RESULT_HIGH, 0);
    check("high", rd, exp_h);
    apb(0, OFF_RESULT_LOW, 0);
    check("low", rd, exp_l);
  endtask : read_pair

  initial begin
    pclk     = 0;
    presetn  = 0;
    psel     = 0;
    penable  = 0;
    pwrite   = 0;
    paddr    = 0;
    pwdata   = 0;
    level    = 0;
    extra    = 0;
    failures = 0;
    compares = 0;
    cycles   = 0;
    ticks    = 0;
    starts   = 0;
    void'($urandom(65251));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STATUS_CTRL, 0);
    check("status", rd, 32'h1F);
    apb(0, OFF_CLOCK_CFG, 0);
    check("cfg", rd, 32'h04);
    check("power", core_power, 0);
    apb(0, 8'h10, 0);
    check("slverr", er, 1);
    check("unmapped", rd, 0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(1023);
      ch = (i == 1) ? 29 : (i == 2) ? 30 : $urandom_range(7);
      level <= v[9:0];
      extra <= 4'($urandom_range(15));
      // divider codes 0, 2, 4, 6 give ratios 1, 4, 16, 16
      cfg = ((2 * i) << 5) | ((i & 1) << 4) | (i << 2);
      apb(1, OFF_CLOCK_CFG, cfg);
      apb(0, OFF_CLOCK_CFG, 0);
      check("cfg readback", rd, cfg);
      apb(1, OFF_STATUS_CTRL, ch);
      @(negedge pclk);
      check("chan", channel_select, ch);
      wait_done();
      v = (ch == 29) ? 1023 : (ch == 30) ? 0 : v;
      level <= ~v[9:0];
      @(negedge pclk);
      t0 = ticks;
      s0 = starts;
      repeat (320) @(posedge pclk);
      @(negedge pclk);
      check("ticks", ticks - t0, 320 / ((i == 0) ? 1 : (i == 1) ? 4 : 16));
      check("starts", starts - s0, 0);
      read_pair(i, v);
      apb(0, OFF_STATUS_CTRL, 0);
      check("done clear", rd[7], 0);
    end
    apb(1, OFF_CLOCK_CFG, 32'h04);
    v = $urandom_range(1023);
    level <= v[9:0];
    apb(1, OFF_STATUS_CTRL, 3);
    wait_done();
    apb(0, OFF_RESULT_HIGH, 0);
    level <= ~v[9:0];
    apb(1, OFF_STATUS_CTRL, 3);
    wait_done();
    apb(0, OFF_RESULT_LOW, 0);
    check("frozen low", rd, v & 255);
    apb(0, OFF_RESULT_HIGH, 0);
    check("kept high", rd, v >> 8);
    apb(0, OFF_RESULT_LOW, 0);
    check("low again", rd, v & 255);
    level <= v[9:0];
    apb(1, OFF_STATUS_CTRL, 32'h22);
    wait_done();
    level <= ~v[9:0];
    repeat (200) @(posedge pclk);
    read_pair(1, ~v & 1023);
    apb(1, OFF_STATUS_CTRL, 29);
    apb(1, OFF_STATUS_CTRL, 30);
    wait_done();
    read_pair(1, 0);
    apb(1, OFF_STATUS_CTRL, 32'h44);
    wait_irq();
    apb(0, OFF_STATUS_CTRL, 0);
    check("irq status", rd, 32'h44);
    apb(0, OFF_RESULT_HIGH, 0);
    @(negedge pclk);
    check("irq read", conv_irq, 0);
    apb(0, OFF_RESULT_LOW, 0);
    apb(1, OFF_STATUS_CTRL, 32'hC4);
    apb(0, OFF_STATUS_CTRL, 0);
    check("done write", rd, 32'hC4);
    wait_irq();
    apb(1, OFF_STATUS_CTRL, 32'h44);
    @(negedge pclk);
    check("irq write", conv_irq, 0);
    apb(1, OFF_STATUS_CTRL, 32'h64);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STATUS_CTRL, 0);
    check("reset status", rd, 32'h1F);
    check("reset irq", conv_irq, 0);
    apb(1, OFF_STATUS_CTRL, 32'h1F);
    repeat (100) @(posedge pclk);
    check("off", core_power, 0);
    apb(0, OFF_STATUS_CTRL, 0);
    check("off status", rd, 32'h1F);
    end_of_test();
  end
endmodule : adc_control_result_logic_bench
`default_nettype wire
